/* File: rtl/osa_pkg.sv */
package osa_pkg;
  typedef logic [31:0] osa_addr_t;
  typedef logic [19:0] osa_page_t;
  typedef logic [11:0] osa_pos_t;
  typedef enum logic [1:0] {
    OSA_BUF0 = 2'b00,
    OSA_BUF1 = 2'b01,
    OSA_BUF_RSV2 = 2'b10,
    OSA_BUF_RSV3 = 2'b11
  } osa_buf_t;
endpackage : osa_pkg

/* File: rtl/osa_plane_start.sv */
`timescale 1ns/1ps
`include "osa_regs.svh"
module osa_plane_start (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ld,
  input wire logic tiled,
  input wire osa_pkg::osa_addr_t base,
  input wire osa_pkg::osa_addr_t lin_off,
  output osa_pkg::osa_addr_t start,
  output osa_pkg::osa_page_t page_idx
);
  osa_pkg::osa_addr_t next_start;
  osa_pkg::osa_page_t next_page_idx;

  always_comb
  begin
    next_start = start;
    next_page_idx = page_idx;
    if (ld)
    begin
      // tiled panning is x,y; linear panning is added here
      if (tiled)
        next_start = base;
      else
        next_start = base + lin_off;
      next_page_idx = next_start[31:`OSA_PAGE_SHIFT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      start <= `OSA_RESET;
      page_idx <= '0;
    end
    else
    begin
      start <= next_start;
      page_idx <= next_page_idx;
    end
  end

  property p_lin_add;
    @(posedge clk) disable iff (!rstn)
    ld && !tiled |=> start == $past(base) + $past(lin_off);
  endproperty
  a_lin_add: assert property (p_lin_add)
    else $error("linear start is not base plus offset");

  property p_page;
    @(posedge clk) disable iff (!rstn)
    page_idx == start[31:`OSA_PAGE_SHIFT];
  endproperty
  a_page: assert property (p_page)
    else $error("page index does not match start address");
endmodule : osa_plane_start

/* File: rtl/osa_regs.svh */
`ifndef OSA_REGS_SVH
`define OSA_REGS_SVH
// on-chip byte offsets
`define OSA_OFS_LUMA0_BASE 20'h00070
`define OSA_OFS_LUMA1_BASE 20'h00074
`define OSA_OFS_CB0_BASE 20'h00078
`define OSA_OFS_CR0_BASE 20'h0007c
`define OSA_OFS_CB1_BASE 20'h00080
`define OSA_OFS_CR1_BASE 20'h00084
`define OSA_OFS_LUMA0_TILE 20'h00088
`define OSA_OFS_LUMA1_TILE 20'h0008c
`define OSA_OFS_CB0_TILE 20'h00090
// debug mirror = on-chip offset + this
`define OSA_DBG_BASE 20'h30100
`define OSA_DBG_PAGE 12'h301
`define OSA_NREGS 9
`define OSA_NBASE 6
`define OSA_RESET 32'h0000_0000
// tiled start fields
`define OSA_TY_MSB 27
`define OSA_TY_LSB 16
`define OSA_TX_MSB 11
`define OSA_TX_LSB 0
// surface page size, 4K
`define OSA_PAGE_SHIFT 12
`endif

/* File: rtl/osa_top.sv */
`timescale 1ns/1ps
`include "osa_regs.svh"
// Notes on behaviour
// - base is aperture offset, translated per page
// - base registers read zero on on-chip path
// - linear mode ignores tiled start registers
// - tiled mode takes x,y start from register
// - bits 27:16 are vertical start lines
// - bits 11:0 are horizontal start pixels
// - vertical mirror: y counts from data end
// - horizontal mirror: x is last pixel
// - linear mode adds buffer offset to base
// - read-write at 70h, debug mirror read-only
// - one command bit selects linear or tiled
// - buffer code 0 or 1, others reserved
module osa_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic cmd_tiled,
  input wire logic [1:0] cmd_mirror,
  input wire logic [1:0] cmd_active_buffer_select,
  input wire logic flip,
  input wire osa_pkg::osa_addr_t [2:0] lin_off,
  input wire osa_pkg::osa_page_t [2:0] gtt_page,
  output logic active_buf,
  output logic fetch_valid,
  output osa_pkg::osa_addr_t [2:0] fetch_start,
  output osa_pkg::osa_page_t [2:0] fetch_index,
  output logic phys_valid,
  output osa_pkg::osa_addr_t [2:0] fetch_phys,
  output osa_pkg::osa_pos_t [1:0] tile_x,
  output osa_pkg::osa_pos_t [1:0] tile_y,
  output logic y_from_end,
  output logic x_is_last
);
  logic [31:0] regs [0:`OSA_NREGS-1];
  logic [31:0] next_regs [0:`OSA_NREGS-1];
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic [5:0] idx;
  logic on_hit;
  logic dbg_hit;

  // one decode serves both windows; low byte picks the register
  always_comb
  begin
    idx = reg_addr[7:2] - 6'h1c;
    on_hit = (reg_addr[19:8] == 12'h000) && (reg_addr[1:0] == 2'b00)
      && (reg_addr[7:0] >= 8'(`OSA_OFS_LUMA0_BASE))
      && (reg_addr[7:0] <= 8'(`OSA_OFS_CB0_TILE));
    dbg_hit = (reg_addr[19:8] == `OSA_DBG_PAGE)
      && (reg_addr[1:0] == 2'b00)
      && (reg_addr[7:0] >= 8'(`OSA_OFS_LUMA0_BASE))
      && (reg_addr[7:0] <= 8'(`OSA_OFS_CB0_TILE));
  end

  always_comb
  begin
    for (int i = 0; i < `OSA_NREGS; i++)
      next_regs[i] = regs[i];
    // debug mirror is read-only, so writes there are dropped
    if (reg_wr && on_hit)
      next_regs[idx[3:0]] = reg_wdata;
    next_rvalid = reg_rd;
    next_rdata = 32'h0000_0000;
    if (reg_rd && dbg_hit)
      next_rdata = regs[idx[3:0]];
    else if (reg_rd && on_hit && idx >= 6'(`OSA_NBASE))
      next_rdata = regs[idx[3:0]];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `OSA_NREGS; i++)
        regs[i] <= `OSA_RESET;
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < `OSA_NREGS; i++)
        regs[i] <= next_regs[i];
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // flip shadow: the fetch sees one consistent set per flip
  osa_pkg::osa_addr_t [2:0] sh_base;
  osa_pkg::osa_addr_t [2:0] next_sh_base;
  osa_pkg::osa_addr_t [2:0] sh_lin;
  osa_pkg::osa_addr_t [2:0] next_sh_lin;
  logic [1:0][31:0] sh_tile;
  logic [1:0][31:0] next_sh_tile;
  logic sh_tiled;
  logic next_sh_tiled;
  logic [1:0] sh_mirror;
  logic [1:0] next_sh_mirror;
  logic ld;
  logic next_ld;
  logic next_active_buf;
  logic sel_ok;
  logic sel1;

  always_comb
  begin
    sel_ok = (cmd_active_buffer_select == osa_pkg::OSA_BUF0)
      || (cmd_active_buffer_select == osa_pkg::OSA_BUF1);
    sel1 = (cmd_active_buffer_select == osa_pkg::OSA_BUF1);
    next_sh_base = sh_base;
    next_sh_lin = sh_lin;
    next_sh_tile = sh_tile;
    next_sh_tiled = sh_tiled;
    next_sh_mirror = sh_mirror;
    next_active_buf = active_buf;
    next_ld = 1'b0;
    // reserved buffer codes leave the last displayed set in place
    if (flip && sel_ok)
    begin
      next_active_buf = sel1;
      next_sh_base[0] = sel1 ? regs[1] : regs[0];
      next_sh_base[1] = sel1 ? regs[4] : regs[2];
      next_sh_base[2] = sel1 ? regs[5] : regs[3];
      next_sh_lin = lin_off;
      next_sh_tile[0] = sel1 ? regs[7] : regs[6];
      // no tiled start register exists for chroma in buffer 1
      next_sh_tile[1] = sel1 ? 32'h0000_0000 : regs[8];
      next_sh_tiled = cmd_tiled;
      next_sh_mirror = cmd_mirror;
      next_ld = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sh_base <= '0;
      sh_lin <= '0;
      sh_tile <= '0;
      sh_tiled <= 1'b0;
      sh_mirror <= 2'b00;
      active_buf <= 1'b0;
      ld <= 1'b0;
    end
    else
    begin
      sh_base <= next_sh_base;
      sh_lin <= next_sh_lin;
      sh_tile <= next_sh_tile;
      sh_tiled <= next_sh_tiled;
      sh_mirror <= next_sh_mirror;
      active_buf <= next_active_buf;
      ld <= next_ld;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_plane
      osa_plane_start u_start (
        .clk(clk),
        .rstn(rstn),
        .ld(ld),
        .tiled(sh_tiled),
        .base(sh_base[p]),
        .lin_off(sh_lin[p]),
        .start(fetch_start[p]),
        .page_idx(fetch_index[p])
      );
    end
  endgenerate

  // window position stage, in step with the start addresses
  osa_pkg::osa_pos_t [1:0] next_tile_x;
  osa_pkg::osa_pos_t [1:0] next_tile_y;
  logic next_y_from_end;
  logic next_x_is_last;
  logic next_fetch_valid;
  logic next_phys_valid;
  osa_pkg::osa_addr_t [2:0] next_fetch_phys;

  always_comb
  begin
    next_tile_x = tile_x;
    next_tile_y = tile_y;
    next_y_from_end = y_from_end;
    next_x_is_last = x_is_last;
    next_fetch_valid = ld;
    if (ld)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (sh_tiled)
        begin
          next_tile_y[i] = sh_tile[i][`OSA_TY_MSB:`OSA_TY_LSB];
          next_tile_x[i] = sh_tile[i][`OSA_TX_MSB:`OSA_TX_LSB];
        end
        else
        begin
          next_tile_y[i] = 12'h000;
          next_tile_x[i] = 12'h000;
        end
      end
      next_y_from_end = sh_tiled && sh_mirror[1];
      next_x_is_last = sh_tiled && sh_mirror[0];
    end
    // table answers in the same cycle the page index is shown
    next_phys_valid = fetch_valid;
    next_fetch_phys = fetch_phys;
    if (fetch_valid)
      for (int i = 0; i < 3; i++)
        next_fetch_phys[i] = {gtt_page[i], fetch_start[i][11:0]};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tile_x <= '0;
      tile_y <= '0;
      y_from_end <= 1'b0;
      x_is_last <= 1'b0;
      fetch_valid <= 1'b0;
      phys_valid <= 1'b0;
      fetch_phys <= '0;
    end
    else
    begin
      tile_x <= next_tile_x;
      tile_y <= next_tile_y;
      y_from_end <= next_y_from_end;
      x_is_last <= next_x_is_last;
      fetch_valid <= next_fetch_valid;
      phys_valid <= next_phys_valid;
      fetch_phys <= next_fetch_phys;
    end
  end

  property p_base_hidden;
    @(posedge clk) disable iff (!rstn)
    reg_rd && on_hit && idx < 6'(`OSA_NBASE) |=> reg_rdata == 32'h0;
  endproperty
  a_base_hidden: assert property (p_base_hidden)
    else $error("base register leaked on on-chip read");

  property p_write;
    @(posedge clk) disable iff (!rstn)
    reg_wr && on_hit && idx == 6'h00 |=> regs[0] == $past(reg_wdata);
  endproperty
  a_write: assert property (p_write)
    else $error("write not captured next cycle");

  property p_dbg_ro;
    @(posedge clk) disable iff (!rstn)
    reg_wr && !on_hit |=> $stable(regs[0]) && $stable(regs[1])
      && $stable(regs[2]) && $stable(regs[3]) && $stable(regs[4])
      && $stable(regs[5]) && $stable(regs[6]) && $stable(regs[7])
      && $stable(regs[8]);
  endproperty
  a_dbg_ro: assert property (p_dbg_ro)
    else $error("debug mirror changed by a write");

  property p_tile_lin;
    @(posedge clk) disable iff (!rstn)
    ld && !sh_tiled |=> tile_x == '0 && tile_y == '0;
  endproperty
  a_tile_lin: assert property (p_tile_lin)
    else $error("tiled start used in linear mode");

  property p_tile_y;
    @(posedge clk) disable iff (!rstn)
    ld && sh_tiled |=> tile_y[0] == $past(sh_tile[0][27:16]);
  endproperty
  a_tile_y: assert property (p_tile_y)
    else $error("vertical start field wrong");

  property p_tile_x;
    @(posedge clk) disable iff (!rstn)
    ld && sh_tiled |=> tile_x[0] == $past(sh_tile[0][11:0]);
  endproperty
  a_tile_x: assert property (p_tile_x)
    else $error("horizontal start field wrong");

  property p_mirror;
    @(posedge clk) disable iff (!rstn)
    flip && sel_ok |-> ##2 y_from_end == $past(cmd_tiled && cmd_mirror[1], 2)
      && x_is_last == $past(cmd_tiled && cmd_mirror[0], 2);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror flags do not follow the flip");

  property p_rsv_buf;
    @(posedge clk) disable iff (!rstn)
    flip && !sel_ok |=> $stable(active_buf) && !ld;
  endproperty
  a_rsv_buf: assert property (p_rsv_buf)
    else $error("reserved buffer code took effect");

  property p_flip_lat;
    @(posedge clk) disable iff (!rstn)
    flip && sel_ok |-> ##2 fetch_valid ##1 phys_valid;
  endproperty
  a_flip_lat: assert property (p_flip_lat)
    else $error("fetch not issued two cycles after flip");

  c_flip0: cover property (@(posedge clk) disable iff (!rstn)
    flip && cmd_active_buffer_select == 2'b00);
  c_flip1_tiled: cover property (@(posedge clk) disable iff (!rstn)
    flip && cmd_active_buffer_select == 2'b01 && cmd_tiled);
  c_dbg_read: cover property (@(posedge clk) disable iff (!rstn)
    reg_rd && dbg_hit);
endmodule : osa_top

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  `define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic flip = 1'b0;
  logic cmd_tiled = 1'b0;
  logic [19:0] reg_addr = 20'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0] cmd_mirror = 2'h0;
  logic [1:0] cmd_active_buffer_select = 2'h0;
  osa_pkg::osa_addr_t [2:0] lin_off = '0;
  osa_pkg::osa_page_t [2:0] gtt_page = '0;
  logic [31:0] reg_rdata;
  logic reg_rvalid, active_buf, fetch_valid, phys_valid;
  logic y_from_end, x_is_last;
  osa_pkg::osa_addr_t [2:0] fetch_start, fetch_phys;
  osa_pkg::osa_page_t [2:0] fetch_index;
  osa_pkg::osa_pos_t [1:0] tile_x, tile_y;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // bench model of the nine registers and the last latched fetch
  logic [31:0] m [9];
  logic [31:0] last_st [3];
  logic exp_buf = 1'b0;

  osa_top uut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cmd_tiled(cmd_tiled),
    .cmd_mirror(cmd_mirror), .cmd_active_buffer_select(cmd_active_buffer_select), .flip(flip),
    .lin_off(lin_off), .gtt_page(gtt_page), .active_buf(active_buf),
    .fetch_valid(fetch_valid), .fetch_start(fetch_start),
    .fetch_index(fetch_index), .phys_valid(phys_valid),
    .fetch_phys(fetch_phys), .tile_x(tile_x), .tile_y(tile_y),
    .y_from_end(y_from_end), .x_is_last(x_is_last)
  );

  always #2.5 clk = ~clk;

  task give_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // a few hundred cycles expected; generous ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  function automatic logic [19:0] ofs(input int i, input logic dbg);
    return (dbg ? 20'h30170 : 20'h00070) + 20'(4 * i);
  endfunction : ofs

  task wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [19:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK(reg_rvalid, 1'b1)
    q = reg_rdata;
  endtask : rd

  task do_flip(input logic t, input logic [1:0] mir, input logic [1:0] ab);
    logic [31:0] lo [3];
    logic [19:0] gp [3];
    int bi [3];
    logic b;
    logic [31:0] tl;
    logic [31:0] tc;
    logic [31:0] st;
    @(posedge clk);
    flip <= 1'b1;
    cmd_tiled <= t;
    cmd_mirror <= mir;
    cmd_active_buffer_select <= ab;
    for (int p = 0; p < 3; p++)
    begin
      lo[p] = $urandom;
      gp[p] = 20'($urandom);
      lin_off[p] <= lo[p];
      gtt_page[p] <= gp[p];
    end
    @(posedge clk);
    flip <= 1'b0;
    if (ab[1])
    begin
      repeat (2) @(negedge clk) `CHK(fetch_valid, 1'b0)
      `CHK(active_buf, exp_buf)
      return;
    end
    exp_buf = ab[0];
    b = ab[0];
    bi[0] = b ? 1 : 0;
    bi[1] = b ? 4 : 2;
    bi[2] = b ? 5 : 3;
    tl = t ? m[6 + b] : 32'h0;
    tc = (t && !b) ? m[8] : 32'h0;
    @(negedge clk);
    `CHK(active_buf, exp_buf)
    @(negedge clk);
    `CHK(fetch_valid, 1'b1)
    for (int p = 0; p < 3; p++)
    begin
      st = t ? m[bi[p]] : m[bi[p]] + lo[p];
      last_st[p] = st;
      `CHK(fetch_start[p], st)
      `CHK(fetch_index[p], st[31:12])
    end
    `CHK(tile_x[0], tl[11:0])
    `CHK(tile_y[0], tl[27:16])
    `CHK(tile_x[1], tc[11:0])
    `CHK(tile_y[1], tc[27:16])
    `CHK(y_from_end, t & mir[1])
    `CHK(x_is_last, t & mir[0])
    @(negedge clk);
    `CHK(phys_valid, 1'b1)
    for (int p = 0; p < 3; p++)
      `CHK(fetch_phys[p], {gp[p], last_st[p][11:0]})
  endtask : do_flip

  initial
  begin
    logic [31:0] q;
    logic [31:0] v;
    void'($urandom(49));
    for (int i = 0; i < 9; i++)
      m[i] = 32'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        rd(ofs(i, 1'b1), q);
        `CHK(q, m[i])
      end
      for (int i = 0; i < 9; i++)
      begin
        v = $urandom;
        // software keeps bases page aligned and reserved bits clear
        v = (i < 6) ? {v[31:12], 12'h0} : v & 32'h0fff_0fff;
        m[i] = v;
        wr(ofs(i, 1'b0), v);
      end
      for (int i = 0; i < 9; i++)
      begin
        rd(ofs(i, 1'b0), q);
        `CHK(q, (i < 6) ? 32'h0 : m[i])
      end
      for (int k = 0; k < 32; k++)
        do_flip(k[4], k[3:2], k[1:0]);
    end
    wr(ofs(0, 1'b1), 32'h1234_5000);
    rd(ofs(0, 1'b1), q);
    `CHK(q, m[0])
    rd(20'h00098, q);
    `CHK(q, 32'h0)
    rd(20'h00089, q);
    `CHK(q, 32'h0)
    do_flip(1'b0, 2'h0, 2'h0);
    m[0] = 32'h00ab_c000;
    wr(ofs(0, 1'b0), m[0]);
    @(negedge clk);
    `CHK(fetch_start[0], last_st[0])
    do_flip(1'b0, 2'h0, 2'h0);
    // mid-run reset must clear the bank again
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    exp_buf = 1'b0;
    @(negedge clk);
    `CHK(active_buf, 1'b0)
    `CHK(fetch_valid, 1'b0)
    `CHK(phys_valid, 1'b0)
    `CHK(reg_rvalid, 1'b0)
    `CHK(fetch_start[0], 32'h0)
    `CHK(fetch_phys[2], 32'h0)
    `CHK(tile_y[0], 12'h000)
    `CHK(tile_x[0], 12'h000)
    for (int i = 0; i < 9; i++)
    begin
      m[i] = 32'h0;
      rd(ofs(i, 1'b1), q);
      `CHK(q, 32'h0)
    end
    give_verdict();
  end
endmodule : testbench
